// ### core/dic_top.sv
// Terminal command interpreter of a motor drive with a Wishbone register port.
// Assumes terminal inputs are synchronous to clk_i and a classic Wishbone master.
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
module dic_top #(
  parameter int UPDN_CYC = dic_pkg::UPDN_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dic_pkg::dic_term_t term_i,
  input wire logic [15:0] analog_ref_i,
  input wire logic keypad_wr_i,
  input wire logic [15:0] keypad_data_i,
  output dic_pkg::dic_ctl_t ctl_o,
  output logic [15:0] freq_ref_o,
  output logic [15:0] setpoint_o,
  output logic fault_relay_out_o,
  output logic [7:0] alarm_code_o
);
  // Sampled terminals and decoded active commands.
  dic_pkg::dic_term_t term_q, act, act_prev;
  logic [22:0] assign_mask, next_assign, polarity, next_polarity;
  logic [3:0] config_r, next_config;
  logic [15:0] max_freq, next_max_freq, keypad_param, next_keypad_param;
  logic [15:0] updn_freq, next_updn_freq, setpoint, next_setpoint;
  logic [15:0] preset_q, mem_bus_q;
  logic trip_latch, next_trip_latch, relay, next_relay;
  logic [7:0] alarm_code, next_alarm_code;
  logic run_fwd, next_run_fwd, run_rev, next_run_rev;
  dic_pkg::dic_ho_t ho_state, next_ho_state;
  logic [13:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic bus_req, bus_pend, next_bus_pend, mem_we;
  logic [31:0] next_dat;
  logic [15:0] src1, src_sel, next_freq;
  logic preset_used, run_any, run_rise, alarm_any;
  dic_pkg::dic_ctl_t next_ctl;

  // Byte-lane merge for register writes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Saturating step used by both up/down accumulators.
  function automatic logic [15:0] step_clamp(input logic [15:0] v, input logic up,
                                             input logic dn, input logic [15:0] top);
    logic [15:0] r;
    r = v;
    if (up && !dn) begin
      r = (v >= top || top - v <= dic_pkg::UPDN_STEP) ? top : v + dic_pkg::UPDN_STEP;
    end else if (dn && !up) begin
      r = (v <= dic_pkg::UPDN_STEP) ? 16'h0000 : v - dic_pkg::UPDN_STEP;
    end
    return r;
  endfunction

  dic_preset_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(wb_adr_i[5:2]),
    .wdata_i(wb_dat_i[15:0]),
    .raddr_a_i({act.preset_sel_bit3, act.preset_sel_bit2, act.preset_sel_bit1,
                act.preset_sel_bit0}),
    .rdata_a_o(preset_q),
    .raddr_b_i(wb_adr_i[5:2]),
    .rdata_b_o(mem_bus_q)
  );

  // Polarity and assignment are applied once, so every decoder sees active-high commands.
  always_comb begin
    act = dic_pkg::dic_term_t'(assign_mask & (term_q ^ polarity ^ dic_pkg::FAILSAFE_MASK));
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    mem_we = bus_req && !bus_pend && wb_we_i && wb_adr_i[7:6] == 2'b01 && wb_sel_i[0];
    tick = (tick_cnt == 14'(UPDN_CYC - 1));
    run_any = act.run_forward_cmd || act.run_reverse_cmd;
    run_rise = run_any && !(act_prev.run_forward_cmd || act_prev.run_reverse_cmd);
    alarm_any = trip_latch || act.external_trip_cmd;
    preset_used = |assign_mask[22:19];
  end

  // Terminal sampling register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle level of the fail-safe trip pin, so release of reset is not seen as a trip.
      term_q <= dic_pkg::FAILSAFE_MASK;
      act_prev <= '0;
    end else begin
      term_q <= term_i;
      act_prev <= act;
    end
  end

  // Register writes; the bus answers two cycles after a request is first seen.
  always_comb begin
    next_assign = assign_mask;
    next_polarity = polarity;
    next_config = config_r;
    next_max_freq = max_freq;
    next_bus_pend = bus_req && !bus_pend;
    next_dat = 32'h0000_0000;
    if (bus_req && !bus_pend && wb_we_i) begin
      case (wb_adr_i)
        dic_pkg::ASSIGN_OFS: next_assign = 23'(lane_merge(32'(assign_mask), wb_dat_i, wb_sel_i));
        dic_pkg::POLARITY_OFS: next_polarity = 23'(lane_merge(32'(polarity), wb_dat_i, wb_sel_i));
        dic_pkg::CONFIG_OFS: next_config = 4'(lane_merge(32'(config_r), wb_dat_i, wb_sel_i));
        dic_pkg::MAX_FREQ_OFS: next_max_freq = 16'(lane_merge(32'(max_freq), wb_dat_i, wb_sel_i));
        default: next_dat = 32'h0000_0000;
      endcase
    end
    // Read data are taken in the second cycle so the table's registered port is ready.
    if (bus_pend) begin
      case (wb_adr_i)
        dic_pkg::ASSIGN_OFS: next_dat = 32'(assign_mask);
        dic_pkg::POLARITY_OFS: next_dat = 32'(polarity);
        dic_pkg::CONFIG_OFS: next_dat = 32'(config_r);
        dic_pkg::MAX_FREQ_OFS: next_dat = 32'(max_freq);
        dic_pkg::STATUS_OFS: next_dat = {22'h000000, ho_state, relay, trip_latch, ctl_o.jog_ready,
                                         ctl_o.run_reverse, ctl_o.run_forward, ctl_o.output_enable,
                                         ctl_o.mains_pickup};
        dic_pkg::FREQ_REF_OFS: next_dat = {16'h0000, freq_ref_o};
        dic_pkg::SETPOINT_OFS: next_dat = {16'h0000, setpoint};
        dic_pkg::KEYPAD_OFS: next_dat = {16'h0000, keypad_param};
        dic_pkg::ALARM_OFS: next_dat = {24'h000000, alarm_code};
        default: next_dat = (wb_adr_i[7:6] == 2'b01) ? {16'h0000, mem_bus_q} : 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_mask <= dic_pkg::ASSIGN_RST;
      polarity <= dic_pkg::POLARITY_RST;
      config_r <= dic_pkg::CONFIG_RST;
      max_freq <= dic_pkg::MAX_FREQ_RST;
      bus_pend <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      assign_mask <= next_assign;
      polarity <= next_polarity;
      config_r <= next_config;
      max_freq <= next_max_freq;
      bus_pend <= next_bus_pend;
      wb_ack_o <= bus_pend;
      wb_dat_o <= next_dat;
    end
  end

  // Alarm, run latch, handover, keypad and up/down state.
  always_comb begin
    next_trip_latch = trip_latch;
    next_relay = relay;
    next_alarm_code = alarm_code;
    if (act.alarm_reset_cmd && !act_prev.alarm_reset_cmd) begin
      next_relay = 1'b0;
    end
    if (!act.alarm_reset_cmd && act_prev.alarm_reset_cmd) begin
      next_trip_latch = 1'b0;
      next_relay = 1'b0;
      next_alarm_code = 8'h00;
    end
    // A trip in the same cycle as a reset edge wins, so it is never lost.
    if (act.external_trip_cmd) begin
      next_trip_latch = 1'b1;
      next_relay = 1'b1;
      next_alarm_code = dic_pkg::EXT_TRIP_ALARM_CODE;
    end
    // Three-wire run: the hold input keeps a pressed direction until hold drops or the other direction is pressed.
    next_run_fwd = act.run_forward_cmd || (act.three_wire_hold && run_fwd && !act.run_reverse_cmd);
    next_run_rev = act.run_reverse_cmd || (act.three_wire_hold && run_rev && !act.run_forward_cmd);
    next_ho_state = ho_state;
    case (ho_state)
      dic_pkg::HO_IDLE: begin
        if (run_rise && (act.mains_handover_fifty || act.mains_handover_sixty)) begin
          next_ho_state = (alarm_any || act.coast_stop_cmd) ? dic_pkg::HO_BLOCKED
                                                             : dic_pkg::HO_MAINS;
        end
      end
      dic_pkg::HO_MAINS: begin
        if (!(next_run_fwd || next_run_rev) || alarm_any) begin
          next_ho_state = dic_pkg::HO_IDLE;
        end
      end
      dic_pkg::HO_BLOCKED: begin
        if (!alarm_any && !act.coast_stop_cmd) begin
          next_ho_state = dic_pkg::HO_IDLE;
        end
      end
      default: next_ho_state = dic_pkg::HO_IDLE;
    endcase
    next_keypad_param = (keypad_wr_i && act.keypad_write_enable) ? keypad_data_i
                                                                 : keypad_param;
    next_tick_cnt = tick ? 14'h0000 : tick_cnt + 14'h0001;
    next_updn_freq = updn_freq;
    next_setpoint = setpoint;
    if (tick) begin
      if (config_r[dic_pkg::CFG_UPDN_PID_BIT]) begin
        next_setpoint = step_clamp(setpoint, act.up_cmd, act.down_cmd,
                                   dic_pkg::SETPOINT_FULL);
      end else begin
        next_updn_freq = step_clamp(updn_freq, act.up_cmd, act.down_cmd, max_freq);
      end
    end
    if (updn_freq > max_freq) begin
      next_updn_freq = max_freq;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_latch <= 1'b0;
      relay <= 1'b0;
      alarm_code <= 8'h00;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      ho_state <= dic_pkg::HO_IDLE;
      keypad_param <= 16'h0000;
      tick_cnt <= 14'h0000;
      updn_freq <= 16'h0000;
      setpoint <= 16'h0000;
    end else begin
      trip_latch <= next_trip_latch;
      relay <= next_relay;
      alarm_code <= next_alarm_code;
      run_fwd <= next_run_fwd;
      run_rev <= next_run_rev;
      ho_state <= next_ho_state;
      keypad_param <= next_keypad_param;
      tick_cnt <= next_tick_cnt;
      updn_freq <= next_updn_freq;
      setpoint <= next_setpoint;
    end
  end

  // Output decode; the first source is either the preset table or the analog input.
  always_comb begin
    next_ctl.pid_enable = config_r[dic_pkg::CFG_PID_EN_BIT] && !act.process_loop_cancel;
    next_ctl.src1_inverse = config_r[dic_pkg::CFG_SRC1_INV_BIT] ^
                            (act.inverse_select && !next_ctl.pid_enable);
    next_ctl.pid_inverse = config_r[dic_pkg::CFG_PID_INV_BIT] ^ act.inverse_select;
    src1 = preset_used ? preset_q
                       : (next_ctl.src1_inverse ? max_freq - analog_ref_i : analog_ref_i);
    src_sel = act.freq_source_select ? updn_freq : src1;
    next_freq = src_sel;
    if (ho_state == dic_pkg::HO_MAINS) begin
      next_freq = act.mains_handover_sixty ? dic_pkg::MAINS_SIXTY_FREQ
                                           : dic_pkg::MAINS_FIFTY_FREQ;
    end
    next_ctl.mains_pickup = (ho_state == dic_pkg::HO_MAINS);
    next_ctl.output_enable = (run_fwd || run_rev) && !act.coast_stop_cmd && !alarm_any &&
                             (ho_state != dic_pkg::HO_BLOCKED);
    next_ctl.run_forward = run_fwd;
    next_ctl.run_reverse = run_rev;
    next_ctl.jog_ready = act.jog_ready_cmd;
    next_ctl.motor_sel = act.motor_select_c ? 2'h3 : act.motor_select_b ? 2'h2 :
                         act.motor_select_a ? 2'h1 : 2'h0;
    next_ctl.torque_limit_sel = act.torque_limit_select;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '0;
      freq_ref_o <= 16'h0000;
      setpoint_o <= 16'h0000;
      fault_relay_out_o <= 1'b0;
      alarm_code_o <= 8'h00;
    end else begin
      ctl_o <= next_ctl;
      freq_ref_o <= next_freq;
      setpoint_o <= setpoint;
      fault_relay_out_o <= relay;
      alarm_code_o <= alarm_code;
    end
  end

  // Checks on the decoded behaviour.
  sequence trip_seen_s;
    act.external_trip_cmd;
  endsequence
  sequence trip_shown_s;
    ##1 (trip_latch && relay) ##1 (!ctl_o.output_enable && fault_relay_out_o);
  endsequence
  coast_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    act.coast_stop_cmd |=> !ctl_o.output_enable && (!relay || $past(alarm_any)))
    else $error("coast stop did not drop output");
  trip_show_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_seen_s |-> trip_shown_s)
    else $error("external trip not shown");
  trip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_latch && !(act_prev.alarm_reset_cmd && !act.alarm_reset_cmd) |=> trip_latch)
    else $error("trip latch lost without reset");
  relay_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(act.alarm_reset_cmd) && !act.external_trip_cmd |-> ##2 !fault_relay_out_o)
    else $error("alarm reset did not drop relay");
  motor_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    act.motor_select_c |=> ctl_o.motor_sel == 2'h3)
    else $error("motor selection wrong");
  src_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    act.freq_source_select && ho_state == dic_pkg::HO_IDLE |=> freq_ref_o == $past(updn_freq))
    else $error("second source not used");
  clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 updn_freq <= max_freq || $changed(max_freq))
    else $error("up down frequency above maximum");
  setpt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    setpoint <= dic_pkg::SETPOINT_FULL)
    else $error("setpoint above full scale");
  keypad_a: assert property (@(posedge clk_i) disable iff (rst_i)
    keypad_wr_i && !act.keypad_write_enable |=> $stable(keypad_param))
    else $error("keypad write accepted while protected");
  hold_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_fwd && act.three_wire_hold && !act.run_reverse_cmd |=> run_fwd)
    else $error("three wire hold lost run");
  blocked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ho_state == dic_pkg::HO_BLOCKED |=> !ctl_o.output_enable && !ctl_o.mains_pickup)
    else $error("blocked handover drove output");
endmodule

// ### core/dic_pkg.sv
// Constants, field layouts and carrier types for the drive input command logic.
// Assumes one 10 MHz clock and a 32-bit classic Wishbone register port.
package dic_pkg;
  // Clock and timing.
  localparam int CLK_NS = 100;
  localparam int UPDN_STEP_US = 1000;
  localparam int UPDN_STEP_CYC = (UPDN_STEP_US * 1000) / CLK_NS;

  // Frequencies in 0.01 Hz units, setpoints in 0.01 % units.
  localparam logic [15:0] MAINS_FIFTY_FREQ = 16'h1388;
  localparam logic [15:0] MAINS_SIXTY_FREQ = 16'h1770;
  localparam logic [15:0] SETPOINT_FULL = 16'h2710;
  localparam logic [15:0] UPDN_STEP = 16'h0001;
  localparam logic [7:0] EXT_TRIP_ALARM_CODE = 8'h02;

  // Register byte offsets.
  localparam logic [7:0] ASSIGN_OFS = 8'h00;
  localparam logic [7:0] POLARITY_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [7:0] MAX_FREQ_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] FREQ_REF_OFS = 8'h14;
  localparam logic [7:0] SETPOINT_OFS = 8'h18;
  localparam logic [7:0] KEYPAD_OFS = 8'h1c;
  localparam logic [7:0] ALARM_OFS = 8'h20;
  localparam logic [7:0] PRESET_BASE_OFS = 8'h40;

  // Configuration register fields.
  localparam int CFG_SRC1_INV_BIT = 0;
  localparam int CFG_PID_EN_BIT = 1;
  localparam int CFG_PID_INV_BIT = 2;
  localparam int CFG_UPDN_PID_BIT = 3;

  // Reset values.
  localparam logic [22:0] ASSIGN_RST = 23'h7fffff;
  localparam logic [22:0] POLARITY_RST = 23'h000000;
  localparam logic [3:0] CONFIG_RST = 4'h0;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1770;

  // One bit per terminal command, sampled from the input terminals.
  typedef struct packed {
    logic preset_sel_bit0;
    logic preset_sel_bit1;
    logic preset_sel_bit2;
    logic preset_sel_bit3;
    logic three_wire_hold;
    logic run_forward_cmd;
    logic run_reverse_cmd;
    logic coast_stop_cmd;
    logic alarm_reset_cmd;
    logic external_trip_cmd;
    logic jog_ready_cmd;
    logic freq_source_select;
    logic motor_select_a;
    logic motor_select_b;
    logic motor_select_c;
    logic torque_limit_select;
    logic mains_handover_fifty;
    logic mains_handover_sixty;
    logic up_cmd;
    logic down_cmd;
    logic keypad_write_enable;
    logic process_loop_cancel;
    logic inverse_select;
  } dic_term_t;

  // Commands whose plain code acts when the terminal is OFF.
  localparam dic_term_t FAILSAFE_MASK = '{external_trip_cmd: 1'b1, default: 1'b0};

  // Drive-facing control word.
  typedef struct packed {
    logic output_enable;
    logic run_forward;
    logic run_reverse;
    logic jog_ready;
    logic [1:0] motor_sel;
    logic torque_limit_sel;
    logic pid_enable;
    logic pid_inverse;
    logic src1_inverse;
    logic mains_pickup;
  } dic_ctl_t;

  // Handover states, one-hot.
  typedef enum logic [2:0] {
    HO_IDLE = 3'b001,
    HO_MAINS = 3'b010,
    HO_BLOCKED = 3'b100
  } dic_ho_t;
endpackage

// ### core/dic_preset_mem.sv
// Sixteen-word preset frequency table with one write port and two read ports.
// Assumes writes come from the register bus; both read ports are registered.
`timescale 1ns/1ps
module dic_preset_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] raddr_a_i,
  output logic [15:0] rdata_a_o,
  input wire logic [3:0] raddr_b_i,
  output logic [15:0] rdata_b_o
);
  logic [15:0] mem [16];

  // Storage holds no reset; software loads the table before use.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end
endmodule

// ### tb/dic_ctrl_model.sv
// Behavioural external sequence controller that drives the drive terminals.
// Assumes the bench gives idle terminal levels and one-cycle sequence requests.
`timescale 1ns/1ps
module dic_ctrl_model #(
  parameter int RST_HOLD = 100000,
  parameter int HO_LEAD = 1000000,
  parameter int HO_OVL = 2000000
) (
  input wire logic clk_i,
  input wire dic_pkg::dic_term_t base_i,
  input wire logic rst_req_i,
  input wire logic ho_req_i,
  output dic_pkg::dic_term_t term_o,
  output logic busy_o
);
  int phase = 0;
  int cnt = 0;
  // Sequence steps; the two handover dwells run one cycle past their minimum because the minimum is strict.
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (phase == 0 && (rst_req_i || ho_req_i)) begin
      phase <= rst_req_i ? 1 : 2;
      cnt <= 0;
    end else if ((phase == 1 && cnt >= RST_HOLD) || (phase == 2 && cnt > HO_LEAD)
        || (phase == 3 && cnt > HO_OVL)) begin
      phase <= (phase == 2) ? 3 : 0;
      cnt <= 0;
    end
  end
  // Overlay of sequenced terminals; only the fifty hertz handover is ever used.
  always_comb begin
    term_o = base_i;
    term_o.alarm_reset_cmd = (phase == 1);
    term_o.mains_handover_fifty = base_i.mains_handover_fifty || phase >= 2;
    term_o.run_forward_cmd = base_i.run_forward_cmd || phase == 3;
    busy_o = (phase != 0);
  end
endmodule

// ### tb/dic_top_tb.sv
// Self-checking bench for the drive input command logic.
// Assumes a 10 MHz clock and the external controller model beside the design.
`timescale 1ns/1ps
module dic_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic ack;
  logic kp_wr = 1'b0;
  logic [15:0] kp_dat = 16'h0;
  logic [15:0] aref = 16'h0;
  logic rreq = 1'b0;
  logic hreq = 1'b0;
  logic busy;
  logic relay;
  logic [7:0] acode;
  logic [15:0] fref;
  logic [15:0] spt;
  logic [7:0] seed = 8'h4e;
  logic [15:0] pre [16];
  dic_pkg::dic_term_t base = '{external_trip_cmd: 1'b1, default: 1'b0};
  dic_pkg::dic_term_t term;
  dic_pkg::dic_ctl_t ctl;
  int err_total = 0;
  int checks_done = 0;

  // Short step time keeps the setpoint ramp to about 20000 cycles.
  dic_top #(.UPDN_CYC(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(rdat), .wb_ack_o(ack), .term_i(term), .analog_ref_i(aref),
    .keypad_wr_i(kp_wr), .keypad_data_i(kp_dat), .ctl_o(ctl), .freq_ref_o(fref),
    .setpoint_o(spt), .fault_relay_out_o(relay), .alarm_code_o(acode));
  dic_ctrl_model #(.RST_HOLD(20), .HO_LEAD(30), .HO_OVL(60)) part_u (.clk_i(clk_i),
    .base_i(base), .rst_req_i(rreq), .ho_req_i(hreq), .term_o(term), .busy_o(busy));

  always #50 clk_i = ~clk_i;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Apply terminal levels, then wait past the two-edge decode latency.
  task automatic setb(input dic_pkg::dic_term_t v);
    @(posedge clk_i);
    base <= v;
    wt(4);
  endtask

  // Classic Wishbone cycle; ack and read data are taken at the rising edge that sees ack high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    chk("ack", 32'(n < 40), 32'h1);
  endtask

  task automatic pulse_req(input logic hand);
    @(posedge clk_i);
    if (hand) hreq <= 1'b1;
    else rreq <= 1'b1;
    @(posedge clk_i);
    hreq <= 1'b0;
    rreq <= 1'b0;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run of about 21000 cycles.
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    conclude();
  end

  initial begin
    dic_pkg::dic_term_t t;
    t = base;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("rst_in", {fref, spt}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk("rst_out", {ctl, relay, acode}, 32'h0);
    bus(1'b0, dic_pkg::ASSIGN_OFS, 32'h0);
    chk("assign", rd, 32'h007fffff);
    bus(1'b0, dic_pkg::MAX_FREQ_OFS, 32'h0);
    chk("max_freq", rd, 32'h00001770);
    bus(1'b1, 8'h30, 32'hffffffff);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Random preset table, then every index selected from the terminals.
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      pre[i] = {seed, lfsr(seed)};
      bus(1'b1, dic_pkg::PRESET_BASE_OFS + 8'(4 * i), {16'h0, pre[i]});
    end
    for (int i = 15; i >= 0; i--) begin
      {t.preset_sel_bit3, t.preset_sel_bit2, t.preset_sel_bit1, t.preset_sel_bit0} = 4'(i);
      setb(t);
      chk("preset", fref, pre[i]);
    end
    t.jog_ready_cmd = 1'b1;
    t.torque_limit_select = 1'b1;
    setb(t);
    chk("jog_tl", {ctl.jog_ready, ctl.torque_limit_sel}, 32'h3);
    bus(1'b1, dic_pkg::POLARITY_OFS, 32'h1000);
    setb(t);
    chk("jog_pol", ctl.jog_ready, 32'h0);
    bus(1'b1, dic_pkg::POLARITY_OFS, 32'h0);
    for (int k = 0; k < 4; k++) begin
      {t.motor_select_c, t.motor_select_b, t.motor_select_a} = 3'((4'h1 << k) >> 1);
      setb(t);
      chk("motor", ctl.motor_sel, 32'(k));
    end
    // Every pairing of the inversion parameter and the inverse-select terminal.
    for (int k = 0; k < 4; k++) begin
      t.inverse_select = k[0];
      t.process_loop_cancel = 1'b0;
      bus(1'b1, dic_pkg::CONFIG_OFS, {29'h0, k[1], 1'b1, k[1]});
      setb(t);
      chk("pid_inv", {ctl.pid_enable, ctl.pid_inverse}, {1'b1, k[1] ^ k[0]});
      t.process_loop_cancel = 1'b1;
      setb(t);
      chk("src1_inv", {ctl.pid_enable, ctl.src1_inverse}, 32'(k[1] ^ k[0]));
    end
    bus(1'b1, dic_pkg::CONFIG_OFS, 32'h0);
    t = '{external_trip_cmd: 1'b1, default: 1'b0};
    t.three_wire_hold = 1'b1;
    t.run_forward_cmd = 1'b1;
    setb(t);
    t.run_forward_cmd = 1'b0;
    setb(t);
    chk("hold", ctl.run_forward, 32'h1);
    t.three_wire_hold = 1'b0;
    setb(t);
    chk("hold_off", ctl.run_forward, 32'h0);
    t.run_reverse_cmd = 1'b1;
    setb(t);
    chk("run", {ctl.output_enable, ctl.run_reverse}, 32'h3);
    t.coast_stop_cmd = 1'b1;
    setb(t);
    chk("coast", {ctl.output_enable, relay, acode}, 32'h0);
    t.coast_stop_cmd = 1'b0;
    t.external_trip_cmd = 1'b0;
    setb(t);
    chk("trip", {ctl.output_enable, relay, acode}, {23'h1, 8'h02});
    t.external_trip_cmd = 1'b1;
    setb(t);
    chk("trip_hold", {relay, acode}, {23'h1, 8'h02});
    bus(1'b0, dic_pkg::STATUS_OFS, 32'h0);
    chk("status", rd, 32'h000000e8);
    pulse_req(1'b0);
    wt(8);
    chk("rst_on", {relay, acode}, 32'h02);
    wt(30);
    chk("rst_off", {busy, relay, acode}, 32'h0);
    t.run_reverse_cmd = 1'b0;
    setb(t);
    pulse_req(1'b1);
    wt(50);
    chk("mains", {ctl.mains_pickup, fref}, {15'h1, dic_pkg::MAINS_FIFTY_FREQ});
    wt(60);
    t.coast_stop_cmd = 1'b1;
    setb(t);
    pulse_req(1'b1);
    wt(50);
    chk("ho_block", {ctl.output_enable, ctl.mains_pickup}, 32'h0);
    t.coast_stop_cmd = 1'b0;
    setb(t);
    chk("ho_clear", {ctl.mains_pickup, ctl.output_enable, fref}, {14'h1, pre[0]});
    wt(60);
    for (int k = 0; k < 2; k++) begin
      t.keypad_write_enable = k[0];
      setb(t);
      seed = lfsr(seed);
      @(posedge clk_i);
      kp_wr <= 1'b1;
      kp_dat <= {seed, ~seed};
      @(posedge clk_i);
      kp_wr <= 1'b0;
      bus(1'b0, dic_pkg::KEYPAD_OFS, 32'h0);
      chk("keypad", rd, k ? {16'h0, seed, ~seed} : 32'h0);
    end
    bus(1'b1, dic_pkg::MAX_FREQ_OFS, 32'h5);
    t.freq_source_select = 1'b1;
    t.up_cmd = 1'b1;
    setb(t);
    wt(40);
    chk("up_clamp", fref, 32'h5);
    t.up_cmd = 1'b0;
    t.down_cmd = 1'b1;
    setb(t);
    wt(40);
    chk("dn_clamp", fref, 32'h0);
    t.freq_source_select = 1'b0;
    setb(t);
    chk("src1", fref, pre[0]);
    bus(1'b1, dic_pkg::CONFIG_OFS, 32'h8);
    t.down_cmd = 1'b0;
    t.up_cmd = 1'b1;
    setb(t);
    wt(20100);
    chk("sp_clamp", spt, 32'h2710);
    // Analog source one with the preset bits unassigned, through every inversion pairing.
    bus(1'b1, dic_pkg::ASSIGN_OFS, 32'h0007ffff);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      aref <= {seed, lfsr(seed)};
      bus(1'b1, dic_pkg::CONFIG_OFS, {31'h0, k[1]});
      t.inverse_select = k[0];
      setb(t);
      chk("analog", fref, (k[1] ^ k[0]) ? 32'(16'(16'h0005 - aref)) : 32'(aref));
    end
    conclude();
  end
endmodule
